// ===== rtl/etseq_pkg.sv
// package: types and constants for the exception trace sequencer
package etseq_pkg;
  localparam int ADDR_W    = 32;
  localparam int EXC_W     = 4;
  localparam int ATOM_W    = 8;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    PKT_ATOM  = 3'h0,
    PKT_WPUPD = 3'h1,
    PKT_EXCBR = 3'h2,
    PKT_BRNCH = 3'h3,
    PKT_ISYNC = 3'h4
  } etseq_pkt_kind_t;

  typedef struct packed {
    etseq_pkt_kind_t    kind;
    logic [EXC_W-1:0]   exc_type;
    logic [ATOM_W-1:0]  atoms;
    logic [3:0]         atom_cnt;
    logic [ADDR_W-1:0]  addr;
  } etseq_pkt_t;

  localparam int PKT_W = $bits(etseq_pkt_t);

  typedef struct packed {
    logic               valid;
    logic               waypoint;
    logic               taken;
    logic               is_return;
    logic [ADDR_W-1:0]  addr;
    logic [ADDR_W-1:0]  target;
  } etseq_instr_t;

  typedef struct packed {
    logic               valid;
    logic [EXC_W-1:0]   exc_type;
    logic [ADDR_W-1:0]  vector;
  } etseq_exc_t;

  localparam logic [3:0]        ATOM_CNT_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST     = 32'h00000000;
endpackage : etseq_pkg

// ===== rtl/etseq_top.sv
// exception trace sequencer with packet fifo
`timescale 1ns/1ns
`default_nettype none

module etseq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage holds no reset: contents are only read while counted valid
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule // etseq_fifo

// What this block does
// - on back-to-back exceptions no single-address comparator reports a match.
// - on back-to-back exceptions every range comparator output holds its previous value.
// - an exception right after a waypoint at the first vector gives the atom packet of that waypoint then the exception branch packet.
// - an exception after a nonwaypoint at the first vector gives a waypoint update then the exception branch.
// - pending atoms go out in an atom header before the waypoint update of an exception, except when a sync is pending: then they stay pending.
// - a handler return is traced as an ordinary branch packet to the return target.
// - trace enabled between back-to-back exceptions gives a sync at the first vector then the exception branch.
// - in that enable-between case no waypoint update is emitted.
// - a trace enable leaves a sync pending for the next traced event, carrying the last waypoint target or exception vector.
// - an exception before any instruction at the sync target follows the sync directly.
// - an exception after instructions past the sync target gives sync, waypoint update, exception branch.
// - each exception branch packet carries the exception kind and its vector address.
// - back-to-back exceptions each get their own exception branch with no waypoint update between.
// - an exception right after an executed waypoint gives its atom packet then the exception branch, with no waypoint update.
module etseq_top
  import etseq_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire etseq_instr_t      INSTR,
  input  wire etseq_exc_t        EXC,
  input  wire logic              TRACE_FILTER_ACTIVE,
  output logic                   CORE_READY,
  input  wire logic              SAC_MATCH_RAW,
  input  wire logic              ARC_MATCH_RAW,
  output logic                   SAC_MATCH,
  output logic                   ARC_MATCH,
  output logic                   PKT_VALID,
  input  wire logic              PKT_READY,
  output etseq_pkt_t             PKT
);
  // one event expands to at most three packets; the core is stalled until they are written to the fifo
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ATOM  = 5'b00010,
    ST_SYNC  = 5'b00100,
    ST_WPUPD = 5'b01000,
    ST_EXCBR = 5'b10000
  } etseq_state_t;

  etseq_state_t       st_q, st_d;
  logic               en_s1_q, en_s2_q, en_prev_q, en_d;
  logic               sync_pend_q, sync_pend_d;
  logic               last_exc_q, last_exc_d;
  logic               exec_since_wp_q, exec_since_wp_d;
  logic [ADDR_W-1:0]  last_instr_q, last_instr_d;
  logic [ADDR_W-1:0]  wp_target_q, wp_target_d;
  logic [ATOM_W-1:0]  atoms_q, atoms_d;
  logic [3:0]         atom_cnt_q, atom_cnt_d;
  etseq_exc_t         exc_q, exc_d;
  logic               sac_q, sac_d, arc_q, arc_d;
  logic               f_valid, f_ready;
  etseq_pkt_t         f_pkt;
  logic               enable_rise, tracing, b2b;

  assign enable_rise = en_s2_q && !en_prev_q;
  assign tracing     = en_s2_q;
  // a stalled exception is not taken yet, so it cannot count as back-to-back
  assign b2b         = EXC.valid && CORE_READY && last_exc_q;
  assign CORE_READY  = (st_q == ST_IDLE) && f_ready;
  assign SAC_MATCH   = sac_q;
  assign ARC_MATCH   = arc_q;

  always_comb begin
    st_d            = st_q;
    en_d            = en_s2_q;
    sync_pend_d     = sync_pend_q;
    last_exc_d      = last_exc_q;
    exec_since_wp_d = exec_since_wp_q;
    last_instr_d    = last_instr_q;
    wp_target_d     = wp_target_q;
    atoms_d         = atoms_q;
    atom_cnt_d      = atom_cnt_q;
    exc_d           = exc_q;
    sac_d           = b2b ? 1'b0 : SAC_MATCH_RAW;
    arc_d           = b2b ? arc_q : ARC_MATCH_RAW;
    f_valid         = 1'b0;
    f_pkt           = '0;
    case (st_q)
      ST_IDLE: begin
        if (!f_ready) begin
          st_d = ST_IDLE;
        end else if (EXC.valid) begin
          exc_d      = EXC;
          last_exc_d = 1'b1;
          if (tracing && (sync_pend_q || enable_rise)) begin
            st_d = ST_SYNC;
          end else if (tracing && atom_cnt_q != ATOM_CNT_RST) begin
            st_d = ST_ATOM;
          end else if (tracing && exec_since_wp_q && !last_exc_q) begin
            st_d = ST_WPUPD;
          end else if (tracing) begin
            st_d = ST_EXCBR;
          end else begin
            exec_since_wp_d = 1'b0;
            // an untraced exception still moves the sync target to its vector
            wp_target_d     = EXC.vector;
          end
        end else if (INSTR.valid) begin
          last_exc_d   = 1'b0;
          last_instr_d = INSTR.addr;
          if (tracing && sync_pend_q) begin
            f_valid     = 1'b1;
            f_pkt.kind  = PKT_ISYNC;
            f_pkt.addr  = wp_target_q;
            sync_pend_d = 1'b0;
          end
          if (INSTR.waypoint) begin
            exec_since_wp_d = 1'b0;
            wp_target_d     = INSTR.taken ? INSTR.target : ADDR_W'(INSTR.addr + 32'h4);
            if (tracing && INSTR.is_return) begin
              st_d = ST_IDLE;
              if (!f_valid) begin
                f_valid    = 1'b1;
                f_pkt.kind = PKT_BRNCH;
                f_pkt.addr = INSTR.target;
              end else begin
                exc_d.vector = INSTR.target;
                st_d         = ST_EXCBR;
                exc_d.valid  = 1'b0;
              end
            end else if (tracing) begin
              atoms_d    = ATOM_W'(atoms_q | (ATOM_W'(INSTR.taken) << atom_cnt_q));
              atom_cnt_d = 4'(atom_cnt_q + 1'b1);
              if (atom_cnt_q == 4'(ATOM_W - 1)) begin
                st_d = ST_ATOM;
                exc_d.valid = 1'b0;
              end
            end
          end else begin
            exec_since_wp_d = 1'b1;
          end
        end
      end
      ST_SYNC: begin
        f_valid     = 1'b1;
        f_pkt.kind  = PKT_ISYNC;
        // enabled between back-to-back exceptions the sync target is the first vector
        f_pkt.addr  = wp_target_q;
        sync_pend_d = 1'b0;
        if (f_ready) begin
          // last_exc_q already marks this event; every exception clears exec_since_wp_q
          st_d = exec_since_wp_q ? ST_WPUPD : ST_EXCBR;
        end
      end
      ST_ATOM: begin
        f_valid        = 1'b1;
        f_pkt.kind     = PKT_ATOM;
        f_pkt.atoms    = atoms_q;
        f_pkt.atom_cnt = atom_cnt_q;
        if (f_ready) begin
          atoms_d    = '0;
          atom_cnt_d = ATOM_CNT_RST;
          if (!exc_q.valid) begin
            st_d = ST_IDLE;
          end else begin
            st_d = exec_since_wp_q ? ST_WPUPD : ST_EXCBR;
          end
        end
      end
      ST_WPUPD: begin
        f_valid    = 1'b1;
        f_pkt.kind = PKT_WPUPD;
        f_pkt.addr = last_instr_q;
        if (f_ready) begin
          st_d            = ST_EXCBR;
          exec_since_wp_d = 1'b0;
        end
      end
      ST_EXCBR: begin
        f_valid = 1'b1;
        if (exc_q.valid) begin
          f_pkt.kind     = PKT_EXCBR;
          f_pkt.exc_type = exc_q.exc_type;
        end else begin
          f_pkt.kind = PKT_BRNCH;
        end
        f_pkt.addr = exc_q.vector;
        if (f_ready) begin
          st_d            = ST_IDLE;
          exec_since_wp_d = 1'b0;
          if (exc_q.valid) begin
            wp_target_d = exc_q.vector; // first vector becomes the sync target
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // set last so a new enable wins over a sync leaving in the same cycle
    if (enable_rise) begin
      sync_pend_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q            <= ST_IDLE;
      en_s1_q         <= 1'b0;
      en_s2_q         <= 1'b0;
      en_prev_q       <= 1'b0;
      sync_pend_q     <= 1'b0;
      last_exc_q      <= 1'b0;
      exec_since_wp_q <= 1'b0;
      last_instr_q    <= ADDR_RST;
      wp_target_q     <= ADDR_RST;
      atoms_q         <= '0;
      atom_cnt_q      <= ATOM_CNT_RST;
      exc_q           <= '0;
      sac_q           <= 1'b0;
      arc_q           <= 1'b0;
    end else begin
      st_q            <= st_d;
      en_s1_q         <= TRACE_FILTER_ACTIVE;
      en_s2_q         <= en_s1_q;
      en_prev_q       <= en_d;
      sync_pend_q     <= sync_pend_d;
      last_exc_q      <= last_exc_d;
      exec_since_wp_q <= exec_since_wp_d;
      last_instr_q    <= last_instr_d;
      wp_target_q     <= wp_target_d;
      atoms_q         <= atoms_d;
      atom_cnt_q      <= atom_cnt_d;
      exc_q           <= exc_d;
      sac_q           <= sac_d;
      arc_q           <= arc_d;
    end
  end

  etseq_fifo #(
    .WIDTH (PKT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RESETN    (RESETN),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_pkt),
    .out_valid (PKT_VALID),
    .out_ready (PKT_READY),
    .out_data  (PKT)
  );
endmodule // etseq_top

`default_nettype wire

// ===== testbench/etseq_chk.sv
// checker: port-level properties of the exception trace sequencer
`timescale 1ns/1ns
`default_nettype none
module etseq_chk
  import etseq_pkg::*;
(
  input wire logic         CLK,
  input wire logic         RESETN,
  input wire etseq_instr_t INSTR,
  input wire etseq_exc_t   EXC,
  input wire logic         TRACE_FILTER_ACTIVE,
  input wire logic         CORE_READY,
  input wire logic         SAC_MATCH_RAW,
  input wire logic         ARC_MATCH_RAW,
  input wire logic         SAC_MATCH,
  input wire logic         ARC_MATCH,
  input wire logic         PKT_VALID,
  input wire logic         PKT_READY,
  input wire etseq_pkt_t   PKT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic exc_acc, ins_acc, b2b, hs;
  logic exc_q, exc_d, wp_q, wp_d, on_q, on_d;
  assign exc_acc = EXC.valid && CORE_READY;
  assign ins_acc = INSTR.valid && CORE_READY && !EXC.valid;
  assign b2b     = exc_acc && exc_q;
  assign hs      = PKT_VALID && PKT_READY;
  // an instruction in between breaks the back-to-back chain
  always_comb begin
    exc_d = exc_acc | (exc_q & ~ins_acc);
    wp_d  = hs ? (PKT.kind == PKT_WPUPD) : wp_q;
    on_d  = on_q | TRACE_FILTER_ACTIVE;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      exc_q <= 1'b0;
      wp_q  <= 1'b0;
      on_q  <= 1'b0;
    end else begin
      exc_q <= exc_d;
      wp_q  <= wp_d;
      on_q  <= on_d;
    end
  end
  sac_clear_a: assert property (b2b |=> !SAC_MATCH)
    else $error("single match after back-to-back");
  sac_follow_a: assert property (!b2b |=> SAC_MATCH == $past(SAC_MATCH_RAW))
    else $error("single match not following raw");
  arc_hold_a: assert property (b2b |=> $stable(ARC_MATCH))
    else $error("range match changed after back-to-back");
  arc_follow_a: assert property (!b2b |=> ARC_MATCH == $past(ARC_MATCH_RAW))
    else $error("range match not following raw");
  wp_then_exc_a: assert property (hs && wp_q |-> PKT.kind == PKT_EXCBR)
    else $error("waypoint update not followed by exception branch");
  pkt_hold_a: assert property (PKT_VALID && !PKT_READY |=> PKT_VALID && $stable(PKT))
    else $error("packet changed while stalled");
  quiet_off_a: assert property (!on_q |-> !PKT_VALID)
    else $error("packet before trace enable");
  ready_back_a: assert property (exc_acc && !PKT_VALID |-> ##[1:5] CORE_READY)
    else $error("core not released after exception");
  cover property (b2b);
  cover property (hs && wp_q);
  cover property (PKT_VALID && !PKT_READY [*4]);
endmodule // etseq_chk

bind etseq_top etseq_chk i_chk (.CLK(CLK), .RESETN(RESETN), .INSTR(INSTR), .EXC(EXC),
  .TRACE_FILTER_ACTIVE(TRACE_FILTER_ACTIVE), .CORE_READY(CORE_READY),
  .SAC_MATCH_RAW(SAC_MATCH_RAW), .ARC_MATCH_RAW(ARC_MATCH_RAW), .SAC_MATCH(SAC_MATCH),
  .ARC_MATCH(ARC_MATCH), .PKT_VALID(PKT_VALID), .PKT_READY(PKT_READY), .PKT(PKT));
`default_nettype wire

// ===== testbench/etseq_sink.sv
// partner: trace capture sink that records packets and can stall
`timescale 1ns/1ns
`default_nettype none
module etseq_sink
  import etseq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       hold,
  input  wire logic       slow,
  input  wire logic       pkt_valid,
  output logic            pkt_ready,
  input  wire etseq_pkt_t pkt
);
  etseq_pkt_t got[$];
  logic       tgl = 1'b0;
  initial pkt_ready = 1'b0;
  // ready moves after the falling edge so the handshake edge sees it settled
  always @(negedge clk) begin
    tgl <= ~tgl;
    pkt_ready <= rst_n && !hold && !(slow && tgl);
  end
  always @(posedge clk) begin
    if (rst_n && pkt_valid && pkt_ready) begin
      got.push_back(pkt);
    end
  end
endmodule // etseq_sink
`default_nettype wire

// ===== testbench/exception_trace_sequencer_test.sv
// testbench: packet order of the exception trace sequencer
`timescale 1ns/1ns
`default_nettype none
module exception_trace_sequencer_test
  import etseq_pkg::*;
;
  localparam logic [3:0]  irq_k = 4'h6;
  localparam logic [3:0]  fiq_k = 4'h7;
  localparam logic [31:0] irq_v = 32'h00000018;
  localparam logic [31:0] fiq_v = 32'h0000001C;
  logic CLK, RESETN = 1'b0, trace_on = 1'b0, sac_raw = 1'b0, arc_raw = 1'b0;
  logic hold = 1'b0, slow = 1'b0, ok, core_ready, sac, arc, pkt_valid, pkt_ready;
  etseq_instr_t instr = '0;
  etseq_exc_t   exc = '0;
  etseq_pkt_t   pkt, exp[$];
  int           mismatches = 0, n_checks = 0, cyc = 0;

  etseq_top i_dut (.CLK(CLK), .RESETN(RESETN), .INSTR(instr), .EXC(exc),
    .TRACE_FILTER_ACTIVE(trace_on), .CORE_READY(core_ready), .SAC_MATCH_RAW(sac_raw),
    .ARC_MATCH_RAW(arc_raw), .SAC_MATCH(sac), .ARC_MATCH(arc), .PKT_VALID(pkt_valid),
    .PKT_READY(pkt_ready), .PKT(pkt));
  etseq_sink i_sink (.clk(CLK), .rst_n(RESETN), .hold(hold), .slow(slow),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // comparator inputs wander so both match paths see traffic
  always @(negedge CLK) begin
    cyc <= cyc + 1;
    sac_raw <= cyc[0];
    arc_raw <= cyc[2];
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // request held until the edge that samples core ready high, then withdrawn
  task automatic send(input etseq_instr_t i, input etseq_exc_t e);
    int n = 0;
    @(negedge CLK);
    instr = i;
    exc = e;
    // core ready depends on the state and the fifo count only, so it is settled at the falling edge
    while (core_ready !== 1'b1 && n < 300) begin
      @(negedge CLK);
      n++;
    end
    ok = (n < 300);
    if (ok) begin
      @(posedge CLK);
      @(negedge CLK);
    end
    instr = '0;
    exc = '0;
  endtask
  task automatic idle();
    @(negedge CLK);
    instr = '0;
    exc = '0;
  endtask
  task automatic nw(input logic [31:0] a);
    send('{1'b1, 1'b0, 1'b0, 1'b0, a, a + 32'h4}, '0);
  endtask
  task automatic wp(input logic [31:0] a, input logic [31:0] t);
    send('{1'b1, 1'b1, 1'b1, 1'b0, a, t}, '0);
  endtask
  task automatic ex(input logic [3:0] ty, input logic [31:0] v);
    send('0, '{1'b1, ty, v});
  endtask
  task automatic trace(input logic v);
    @(negedge CLK);
    trace_on = v;
    repeat (4) @(posedge CLK);
  endtask
  // atom packets carry count and atoms in a[11:0]
  function automatic void px(etseq_pkt_kind_t k, logic [3:0] t, logic [31:0] a);
    exp.push_back('{k, t, a[7:0], a[11:8], a});
  endfunction
  task automatic flush();
    etseq_pkt_t e, g;
    int n = 0;
    idle();
    while ((i_sink.got.size() < exp.size() || pkt_valid) && n < 400) begin
      @(posedge CLK);
      n++;
    end
    repeat (8) @(posedge CLK);
    cmp("count", 32'(exp.size()), 32'(i_sink.got.size()));
    while (exp.size() > 0 && i_sink.got.size() > 0) begin
      e = exp.pop_front();
      g = i_sink.got.pop_front();
      cmp("kind", 32'(e.kind), 32'(g.kind));
      if (e.kind == PKT_ATOM) begin
        cmp("atoms", {20'h0, e.atom_cnt, e.atoms}, {20'h0, g.atom_cnt, g.atoms});
      end else begin
        cmp("addr", e.addr, g.addr);
      end
      if (e.kind == PKT_EXCBR) begin
        cmp("exc_type", 32'(e.exc_type), 32'(g.exc_type));
      end
    end
    exp.delete();
    i_sink.got.delete();
  endtask

  task automatic t_nonwp_b2b();
    trace(1'b1);
    wp(32'h0F00, 32'h1000);
    nw(32'h1000);
    ex(irq_k, irq_v);
    ex(fiq_k, fiq_v);
    px(PKT_ISYNC, 4'h0, ADDR_RST);
    px(PKT_ATOM, 4'h0, 32'h101);
    px(PKT_WPUPD, 4'h0, 32'h1000);
    px(PKT_EXCBR, irq_k, irq_v);
    px(PKT_EXCBR, fiq_k, fiq_v);
    flush();
  endtask
  task automatic t_vec_wp();
    ex(irq_k, irq_v);
    wp(irq_v, 32'h3000);
    ex(fiq_k, fiq_v);
    px(PKT_EXCBR, irq_k, irq_v);
    px(PKT_ATOM, 4'h0, 32'h101);
    px(PKT_EXCBR, fiq_k, fiq_v);
    flush();
  endtask
  task automatic t_vec_nw();
    slow = 1'b1;
    ex(irq_k, irq_v);
    nw(irq_v);
    ex(fiq_k, fiq_v);
    px(PKT_EXCBR, irq_k, irq_v);
    px(PKT_WPUPD, 4'h0, irq_v);
    px(PKT_EXCBR, fiq_k, fiq_v);
    flush();
    slow = 1'b0;
  endtask
  task automatic t_return();
    send('{1'b1, 1'b1, 1'b1, 1'b1, 32'h2100, 32'h1004}, '0);
    px(PKT_BRNCH, 4'h0, 32'h1004);
    flush();
    // a return as the first instruction after enable follows its sync
    trace(1'b0);
    trace(1'b1);
    send('{1'b1, 1'b1, 1'b1, 1'b1, 32'h2100, 32'h3000}, '0);
    px(PKT_ISYNC, 4'h0, 32'h1004);
    px(PKT_BRNCH, 4'h0, 32'h3000);
    flush();
  endtask
  task automatic t_on_exc();
    trace(1'b0);
    wp(32'h3100, 32'h4000);
    trace(1'b1);
    ex(irq_k, irq_v);
    px(PKT_ISYNC, 4'h0, 32'h4000);
    px(PKT_EXCBR, irq_k, irq_v);
    flush();
  endtask
  task automatic t_on_nw();
    trace(1'b0);
    wp(32'h4F00, 32'h5000);
    trace(1'b1);
    nw(32'h5000);
    nw(32'h5004);
    ex(irq_k, irq_v);
    px(PKT_ISYNC, 4'h0, 32'h5000);
    px(PKT_WPUPD, 4'h0, 32'h5004);
    px(PKT_EXCBR, irq_k, irq_v);
    flush();
    // instructions run while tracing was off, then enable and exception
    trace(1'b0);
    wp(32'h5F00, 32'h6000);
    nw(32'h6000);
    trace(1'b1);
    ex(fiq_k, fiq_v);
    px(PKT_ISYNC, 4'h0, 32'h6000);
    px(PKT_WPUPD, 4'h0, 32'h6000);
    px(PKT_EXCBR, fiq_k, fiq_v);
    flush();
  endtask
  task automatic t_on_b2b();
    trace(1'b0);
    ex(irq_k, irq_v);
    trace(1'b1);
    ex(fiq_k, fiq_v);
    px(PKT_ISYNC, 4'h0, irq_v);
    px(PKT_EXCBR, fiq_k, fiq_v);
    flush();
  endtask
  // fifo filled with the sink stalled until the core is refused, then drained
  task automatic t_fill();
    hold = 1'b1;
    ok = 1'b1;
    for (int i = 0; i < 40 && ok; i++) begin
      send('{1'b1, 1'b1, 1'b1, 1'b1, 32'h8000, 32'h100 + 32'(i * 4)}, '0);
      if (ok) px(PKT_BRNCH, 4'h0, 32'h100 + 32'(i * 4));
    end
    idle();
    hold = 1'b0;
    cmp("refused", 32'h0, {31'h0, ok});
    flush();
    cmp("pkt_valid", 32'h0, {31'h0, pkt_valid});
  endtask

  initial begin
    repeat (6) @(posedge CLK);
    @(negedge CLK);
    RESETN = 1'b1;
    t_nonwp_b2b();
    t_vec_wp();
    t_vec_nw();
    t_return();
    t_on_exc();
    t_on_nw();
    t_on_b2b();
    t_fill();
    finish_test();
  end
endmodule // exception_trace_sequencer_test
`default_nettype wire
